//--- verilog/timer_mask_stop.sv
// AXI4-Lite register bank for timer interrupt masks and timer/watchdog clock stop.
//
// Notes on behaviour
// RQ1: Mask register is read-only, reset zero.
// RQ2: Masks change only via set/clear registers.
// RQ3: Bits 23:16 hold half-match masks, 1 masks.
// RQ4: Bits 7:0 hold full-match masks, 1 masks.
// RQ5: Mask reserved bits read zero, writes ignored.
// RQ6: Mask-set bit 16+n sets half mask n.
// RQ7: Mask-set bit n sets full mask n.
// RQ8: Mask-clear bit 16+n clears half mask n.
// RQ9: Mask-clear bit n clears full mask n.
// RQ10: Stop register read-only, reset zero, set/clear only.
// RQ11: Stop bit withholds that timer's or watchdog's clock.
// RQ12: Stopped unit's registers inaccessible until stop cleared.
// RQ13: Stop bit 16 shows watchdog clock stopped.
// RQ14: Stop bits 7:0 show channel clocks; rest zero.
// RQ15: Stop-set bit 16 stops the watchdog clock.
// RQ16: Stop-set bit n stops channel n clock.
// RQ17: One write changes all selected channels together.
// RQ18: Stop-clear bit 16 or n restarts that clock.
// RQ19: Masks act on half and full match flags.
// RQ20: Request when flag set and mask clear.
// RQ21: Set/clear registers read zero, act next cycle.
`timescale 1ns/1ps

module timer_mask_stop
#(
	parameter int CHANNELS   = timer_mask_stop_pkg::CHANNEL_COUNT,
	parameter int ADDR_WIDTH = timer_mask_stop_pkg::ADDR_WIDTH
)
(
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic                  clock_enable,
	input  wire logic                  awvalid,
	output logic                       awready,
	input  wire logic [ADDR_WIDTH-1:0] awaddr,
	input  wire logic [2:0]            awprot,
	input  wire logic                  wvalid,
	output logic                       wready,
	input  wire logic [31:0]           wdata,
	input  wire logic [3:0]            wstrb,
	output logic                       bvalid,
	input  wire logic                  bready,
	output logic [1:0]                 bresp,
	input  wire logic                  arvalid,
	output logic                       arready,
	input  wire logic [ADDR_WIDTH-1:0] araddr,
	input  wire logic [2:0]            arprot,
	output logic                       rvalid,
	input  wire logic                  rready,
	output logic [31:0]                rdata,
	output logic [1:0]                 rresp,
	input  wire logic [7:0]            half_match_flag,
	input  wire logic [7:0]            full_match_flag,
	output logic [7:0]                 half_match_irq,
	output logic [7:0]                 full_match_irq,
	output logic [7:0]                 channel_irq,
	output logic [7:0]                 channel_clock_enable,
	output logic                       watchdog_clock_enable,
	output logic [7:0]                 channel_access_enable,
	output logic                       watchdog_access_enable
);

	timer_mask_stop_pkg::state_type state_q;
	timer_mask_stop_pkg::state_type state_d;

	logic [7:0]  lanes;
	logic [7:0]  half_request;
	logic [7:0]  full_request;
	logic [31:0] strobe_bits;
	logic [31:0] write_bits;
	logic [31:0] mask_word;
	logic [31:0] stop_word;
	logic [31:0] pending_word;
	logic        aw_take;
	logic        w_take;
	logic        ar_take;
	logic        aw_now;
	logic        w_now;
	logic [7:0]  aw_offset;
	logic [7:0]  ar_offset;
	logic [31:0] w_data_now;
	logic [3:0]  w_strb_now;

	// The bit layout gives room for eight channels only.
	if (CHANNELS < 1 || CHANNELS > 8)
	begin : channel_check
		$error("CHANNELS must lie between 1 and 8.");
	end
	if (ADDR_WIDTH < 8)
	begin : addr_check
		$error("ADDR_WIDTH must be at least 8.");
	end

	// Channels beyond CHANNELS keep constant zero state.
	assign lanes = 8'((9'h001 << CHANNELS) - 9'h001);

	// Per-channel request logic; a flag still sets while its request is masked.
	for (genvar n = 0; n < 8; n++)
	begin : channel_gen
		assign half_request[n] = lanes[n] & half_match_flag[n] & ~state_q.mask.half[n]; // see RQ19 RQ20
		assign full_request[n] = lanes[n] & full_match_flag[n] & ~state_q.mask.full[n]; // see RQ19 RQ20
	end

	// Readback images of the status registers.
	always_comb
	begin
		mask_word = '0; // see RQ5
		mask_word[timer_mask_stop_pkg::HALF_LSB +: 8] = state_q.mask.half; // see RQ3
		mask_word[timer_mask_stop_pkg::FULL_LSB +: 8] = state_q.mask.full; // see RQ4
		stop_word = '0; // see RQ14
		stop_word[timer_mask_stop_pkg::WATCHDOG_BIT] = state_q.stop.watchdog; // see RQ13
		stop_word[timer_mask_stop_pkg::CHANNEL_LSB +: 8] = state_q.stop.channel; // see RQ14
		pending_word = '0;
		pending_word[timer_mask_stop_pkg::HALF_LSB +: 8] = state_q.half_irq;
		pending_word[timer_mask_stop_pkg::FULL_LSB +: 8] = state_q.full_irq;
	end

	// A frozen block refuses every address and write-data transfer so that nothing is lost while clock_enable is low.
	assign awready = clock_enable & ~state_q.aw.held & ~state_q.b.valid;
	assign wready  = clock_enable & ~state_q.w.held & ~state_q.b.valid;
	assign arready = clock_enable & ~state_q.r.valid;
	assign aw_take = awvalid & awready;
	assign w_take  = wvalid & wready;
	assign ar_take = arvalid & arready;

	assign aw_now     = state_q.aw.held | aw_take;
	assign w_now      = state_q.w.held | w_take;
	assign aw_offset  = state_q.aw.held ? state_q.aw.addr[7:0] : awaddr[7:0];
	assign ar_offset  = araddr[7:0];
	assign w_data_now = state_q.w.held ? state_q.w.data : wdata;
	assign w_strb_now = state_q.w.held ? state_q.w.strb : wstrb;

	// Byte lanes without a strobe contribute no set or clear action.
	for (genvar k = 0; k < 4; k++)
	begin : strobe_gen
		assign strobe_bits[k*8 +: 8] = {8{w_strb_now[k]}};
	end
	assign write_bits = w_data_now & strobe_bits;

	always_comb
	begin
		state_d = state_q;

		// Requests are registered so half_match_irq and full_match_irq come straight from flops; channel_irq is their OR.
		state_d.half_irq = half_request; // see RQ20
		state_d.full_irq = full_request; // see RQ20

		// Answer channels release once taken.
		if (state_q.b.valid && bready)
		begin
			state_d.b.valid = 1'b0;
		end
		if (state_q.r.valid && rready)
		begin
			state_d.r.valid = 1'b0;
		end

		// Address and data may arrive in either order; each is held until both are here.
		if (aw_take)
		begin
			state_d.aw.held = 1'b1;
			state_d.aw.addr = awaddr[timer_mask_stop_pkg::ADDR_WIDTH-1:0];
		end
		if (w_take)
		begin
			state_d.w.held = 1'b1;
			state_d.w.data = wdata;
			state_d.w.strb = wstrb;
		end

		// Every selected bit of one write changes at the same edge.
		if (aw_now && w_now && !state_q.b.valid)
		begin
			state_d.aw.held = 1'b0;
			state_d.w.held  = 1'b0;
			state_d.b.valid = 1'b1;
			state_d.b.resp  = timer_mask_stop_pkg::RESP_OKAY;
			state_d.b.data  = '0;
			unique case (aw_offset[7:2])
				timer_mask_stop_pkg::MASK_SET_OFFSET[7:2]:
				begin
					state_d.mask.half = state_q.mask.half
						| (write_bits[timer_mask_stop_pkg::HALF_LSB +: 8] & lanes); // see RQ6 RQ17
					state_d.mask.full = state_q.mask.full
						| (write_bits[timer_mask_stop_pkg::FULL_LSB +: 8] & lanes); // see RQ7 RQ17
				end
				timer_mask_stop_pkg::MASK_CLEAR_OFFSET[7:2]:
				begin
					state_d.mask.half = state_q.mask.half
						& ~write_bits[timer_mask_stop_pkg::HALF_LSB +: 8]; // see RQ8 RQ17
					state_d.mask.full = state_q.mask.full
						& ~write_bits[timer_mask_stop_pkg::FULL_LSB +: 8]; // see RQ9 RQ17
				end
				timer_mask_stop_pkg::STOP_SET_OFFSET[7:2]:
				begin
					state_d.stop.watchdog = state_q.stop.watchdog
						| write_bits[timer_mask_stop_pkg::WATCHDOG_BIT]; // see RQ15 RQ17
					state_d.stop.channel = state_q.stop.channel
						| (write_bits[timer_mask_stop_pkg::CHANNEL_LSB +: 8] & lanes); // see RQ16 RQ17
				end
				timer_mask_stop_pkg::STOP_CLEAR_OFFSET[7:2]:
				begin
					state_d.stop.watchdog = state_q.stop.watchdog
						& ~write_bits[timer_mask_stop_pkg::WATCHDOG_BIT]; // see RQ18 RQ17
					state_d.stop.channel = state_q.stop.channel
						& ~write_bits[timer_mask_stop_pkg::CHANNEL_LSB +: 8]; // see RQ18 RQ17
				end
				// Status registers accept the write and keep their value.
				timer_mask_stop_pkg::MASK_STATUS_OFFSET[7:2],
				timer_mask_stop_pkg::STOP_STATUS_OFFSET[7:2],
				timer_mask_stop_pkg::PENDING_STATUS_OFFSET[7:2]:
				begin
					state_d.b.resp = timer_mask_stop_pkg::RESP_OKAY; // see RQ1 RQ2 RQ10
				end
				default:
				begin
					state_d.b.resp = timer_mask_stop_pkg::RESP_SLVERR;
				end
			endcase
		end

		// Read data is captured at the same edge that takes the address.
		if (ar_take)
		begin
			state_d.r.valid = 1'b1;
			state_d.r.resp  = timer_mask_stop_pkg::RESP_OKAY;
			unique case (ar_offset[7:2])
				timer_mask_stop_pkg::MASK_STATUS_OFFSET[7:2]:
				begin
					state_d.r.data = mask_word; // see RQ1 RQ3 RQ4 RQ5
				end
				timer_mask_stop_pkg::STOP_STATUS_OFFSET[7:2]:
				begin
					state_d.r.data = stop_word; // see RQ10 RQ13 RQ14
				end
				timer_mask_stop_pkg::PENDING_STATUS_OFFSET[7:2]:
				begin
					state_d.r.data = pending_word;
				end
				timer_mask_stop_pkg::MASK_SET_OFFSET[7:2],
				timer_mask_stop_pkg::MASK_CLEAR_OFFSET[7:2],
				timer_mask_stop_pkg::STOP_SET_OFFSET[7:2],
				timer_mask_stop_pkg::STOP_CLEAR_OFFSET[7:2]:
				begin
					state_d.r.data = '0; // see RQ21
				end
				default:
				begin
					state_d.r.data = '0;
					state_d.r.resp = timer_mask_stop_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_q.mask.half     <= timer_mask_stop_pkg::MASK_RESET; // see RQ1
			state_q.mask.full     <= timer_mask_stop_pkg::MASK_RESET; // see RQ1
			state_q.stop.watchdog <= timer_mask_stop_pkg::WATCHDOG_RESET; // see RQ10
			state_q.stop.channel  <= timer_mask_stop_pkg::STOP_RESET; // see RQ10
			state_q.half_irq      <= '0;
			state_q.full_irq      <= '0;
			state_q.aw            <= '0;
			state_q.w             <= '0;
			state_q.b             <= '0;
			state_q.r             <= '0;
		end
		else if (clock_enable)
		begin
			state_q <= state_d; // see RQ21
		end
	end

	assign bvalid = state_q.b.valid;
	assign bresp  = state_q.b.resp;
	assign rvalid = state_q.r.valid;
	assign rdata  = state_q.r.data;
	assign rresp  = state_q.r.resp;

	assign half_match_irq = state_q.half_irq;
	assign full_match_irq = state_q.full_irq;
	assign channel_irq    = state_q.half_irq | state_q.full_irq; // see RQ20

	// Enables feed clock gates in the timer channels; each is its stop flop inverted, and channel enables are also ANDed with lanes.
	assign channel_clock_enable  = ~state_q.stop.channel & lanes; // see RQ11
	assign watchdog_clock_enable = ~state_q.stop.watchdog; // see RQ11

	// A stopped unit has no clock, so its register port must refuse software.
	assign channel_access_enable  = ~state_q.stop.channel & lanes; // see RQ12
	assign watchdog_access_enable = ~state_q.stop.watchdog; // see RQ12

endmodule // timer_mask_stop

//--- verilog/timer_mask_stop_pkg.sv
// Constants and types shared by the timer mask and clock-stop register bank.
package timer_mask_stop_pkg;

	// Bus geometry.
	localparam int DATA_WIDTH     = 32;
	localparam int STRB_WIDTH     = 4;
	localparam int ADDR_WIDTH     = 8;
	localparam int CHANNEL_COUNT  = 8;

	// Register byte offsets.
	localparam logic [7:0] STOP_STATUS_OFFSET    = 8'h1C;
	localparam logic [7:0] STOP_SET_OFFSET       = 8'h2C;
	localparam logic [7:0] MASK_STATUS_OFFSET    = 8'h30;
	localparam logic [7:0] MASK_SET_OFFSET       = 8'h34;
	localparam logic [7:0] MASK_CLEAR_OFFSET     = 8'h38;
	localparam logic [7:0] STOP_CLEAR_OFFSET     = 8'h3C;
	localparam logic [7:0] PENDING_STATUS_OFFSET = 8'h40;

	// Field positions.
	localparam int HALF_LSB     = 16;
	localparam int FULL_LSB     = 0;
	localparam int WATCHDOG_BIT = 16;
	localparam int CHANNEL_LSB  = 0;

	// Reset values.
	localparam logic [7:0] MASK_RESET     = 8'h00;
	localparam logic [7:0] STOP_RESET     = 8'h00;
	localparam logic       WATCHDOG_RESET = 1'b0;

	// Bus responses.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [7:0] half;
		logic [7:0] full;
	} mask_type;

	typedef struct packed {
		logic       watchdog;
		logic [7:0] channel;
	} stop_type;

	typedef struct packed {
		logic                  held;
		logic [ADDR_WIDTH-1:0] addr;
	} addr_hold_type;

	typedef struct packed {
		logic                  held;
		logic [DATA_WIDTH-1:0] data;
		logic [STRB_WIDTH-1:0] strb;
	} data_hold_type;

	typedef struct packed {
		logic                  valid;
		logic [1:0]            resp;
		logic [DATA_WIDTH-1:0] data;
	} answer_type;

	typedef struct packed {
		mask_type      mask;
		stop_type      stop;
		logic [7:0]    half_irq;
		logic [7:0]    full_irq;
		addr_hold_type aw;
		data_hold_type w;
		answer_type    b;
		answer_type    r;
	} state_type;

endpackage

//--- testbench/timer_mask_stop_checker.sv
// Concurrent checks on the ports of the timer mask and clock-stop bank.
`timescale 1ns/1ps

module timer_mask_stop_checker
(
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic [1:0]  bresp,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic [31:0] rdata,
	input wire logic [7:0]  half_match_flag,
	input wire logic [7:0]  full_match_flag,
	input wire logic [7:0]  half_match_irq,
	input wire logic [7:0]  full_match_irq,
	input wire logic [7:0]  channel_irq,
	input wire logic [7:0]  channel_clock_enable,
	input wire logic        watchdog_clock_enable,
	input wire logic [7:0]  channel_access_enable,
	input wire logic        watchdog_access_enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	a_write_answer: assert property (awvalid && awready && wvalid && wready |=> bvalid)
		else $error("write response missing after handshake");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read data missing after handshake");
	a_bresp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped before bready");
	a_read_reserved: assert property (rvalid |-> rdata[31:24] == 8'h00
		&& rdata[15:8] == 8'h00)
		else $error("reserved read bits not zero");
	a_half_irq_cause: assert property ((half_match_irq & ~$past(half_match_flag))
		== 8'h00)
		else $error("half match request without flag");
	a_full_irq_cause: assert property ((full_match_irq & ~$past(full_match_flag))
		== 8'h00)
		else $error("full match request without flag");
	a_irq_merge: assert property (channel_irq == (half_match_irq | full_match_irq))
		else $error("channel request not the merge of both");
	a_access_follows: assert property ({channel_access_enable, watchdog_access_enable}
		== {channel_clock_enable, watchdog_clock_enable})
		else $error("access enable differs from clock enable");
	a_stop_by_write: assert property (
		$changed({watchdog_clock_enable, channel_clock_enable}) |-> $rose(bvalid))
		else $error("clock enable changed without a write");

	c_write: cover property (awvalid && awready && wvalid && wready);
	c_read: cover property (rvalid && rready);
	c_irq: cover property (channel_irq != 8'h00);
	c_stop: cover property ($fell(watchdog_clock_enable));
endmodule // timer_mask_stop_checker

bind timer_mask_stop timer_mask_stop_checker i_timer_mask_stop_checker (.clk, .reset, .awvalid,
	.awready, .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready,
	.rdata,
	.half_match_flag, .full_match_flag, .half_match_irq, .full_match_irq, .channel_irq,
	.channel_clock_enable, .watchdog_clock_enable, .channel_access_enable, .watchdog_access_enable);

//--- testbench/tb.sv
// Self-checking testbench for the timer mask and clock-stop bank.
`timescale 1ns/1ps

module tb;
	typedef struct packed {
		logic [7:0]  wa;
		logic [31:0] wd;
		logic [7:0]  ra;
		logic [31:0] ex;
	} row_type;

	logic        clk = 1'b0, reset = 1'b1, clock_enable = 1'b1;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, half_match_flag = 8'h00, full_match_flag = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0]  wstrb = 4'hF;
	logic [2:0]  awprot = 3'h0, arprot = 3'h0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        watchdog_clock_enable, watchdog_access_enable;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [7:0]  half_match_irq, full_match_irq, channel_irq;
	logic [7:0]  channel_clock_enable, channel_access_enable;
	logic [8:0]  expect_on;
	int          failures = 0, comparisons = 0, cycles = 0;
	row_type     rows [8];

	timer_mask_stop i_timer_mask_stop (.clk, .reset, .clock_enable, .awvalid, .awready, .awaddr,
		.awprot, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
		.araddr, .arprot, .rvalid, .rready, .rdata, .rresp, .half_match_flag, .full_match_flag,
		.half_match_irq, .full_match_irq, .channel_irq, .channel_clock_enable,
		.watchdog_clock_enable, .channel_access_enable, .watchdog_access_enable);

	always #2.5 clk = ~clk;

	task automatic stop_test();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			failures++;
			stop_test();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Ready is sampled on the falling edge so the release at the next rising edge never races.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ad, dd, ta, tw;
		ad = 1'b0;
		dd = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && dd))
		begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			ad = ad | ta;
			dd = dd | tw;
		end
		do @(negedge clk); while (!bvalid);
		chk("bresp", {30'h0, er}, {30'h0, bresp});
		@(posedge clk);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge clk); while (!arready);
		@(posedge clk);
		arvalid <= 1'b0;
		do @(negedge clk); while (!rvalid);
		chk("rdata", e, rdata);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
		@(posedge clk);
		rready <= 1'b0;
	endtask

	initial
	begin
		rows[0] = {timer_mask_stop_pkg::MASK_STATUS_OFFSET, 32'hFFFFFFFF,
			timer_mask_stop_pkg::MASK_STATUS_OFFSET, 32'h00000000};
		rows[1] = {timer_mask_stop_pkg::MASK_SET_OFFSET, 32'hFFFFFFFF,
			timer_mask_stop_pkg::MASK_STATUS_OFFSET, 32'h00FF00FF};
		rows[2] = {timer_mask_stop_pkg::MASK_CLEAR_OFFSET, 32'h00A5005A,
			timer_mask_stop_pkg::MASK_STATUS_OFFSET, 32'h005A00A5};
		rows[3] = {timer_mask_stop_pkg::MASK_CLEAR_OFFSET, 32'hFFFFFFFF,
			timer_mask_stop_pkg::MASK_SET_OFFSET, 32'h00000000};
		rows[4] = {timer_mask_stop_pkg::STOP_STATUS_OFFSET, 32'hFFFFFFFF,
			timer_mask_stop_pkg::STOP_STATUS_OFFSET, 32'h00000000};
		rows[5] = {timer_mask_stop_pkg::STOP_SET_OFFSET, 32'hFFFFFFFF,
			timer_mask_stop_pkg::STOP_STATUS_OFFSET, 32'h000100FF};
		rows[6] = {timer_mask_stop_pkg::STOP_CLEAR_OFFSET, 32'h00010081,
			timer_mask_stop_pkg::STOP_STATUS_OFFSET, 32'h0000007E};
		rows[7] = {timer_mask_stop_pkg::MASK_SET_OFFSET, 32'h00000001,
			timer_mask_stop_pkg::MASK_STATUS_OFFSET, 32'h00000001};
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		foreach (rows[i])
		begin
			wr(rows[i].wa, rows[i].wd, timer_mask_stop_pkg::RESP_OKAY);
			rd(rows[i].ra, rows[i].ex,
				timer_mask_stop_pkg::RESP_OKAY);
			if (rows[i].ra == timer_mask_stop_pkg::STOP_STATUS_OFFSET)
			begin
				expect_on = ~{rows[i].ex[16], rows[i].ex[7:0]};
				chk("clock enables", {23'h0, expect_on},
					{23'h0, watchdog_clock_enable, channel_clock_enable});
				chk("access enables", {23'h0, expect_on},
					{23'h0, watchdog_access_enable, channel_access_enable});
			end
			$display("row %0d done", i);
		end
		wr(8'h04, 32'hFFFFFFFF, timer_mask_stop_pkg::RESP_SLVERR);
		rd(8'h04, 32'h00000000, timer_mask_stop_pkg::RESP_SLVERR);
		$display("unmapped done");
		@(posedge clk);
		half_match_flag <= 8'h0F;
		full_match_flag <= 8'h03;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk("requests", {8'h0F, 8'h02, 8'h0F},
			{half_match_irq, full_match_irq, channel_irq});
		rd(timer_mask_stop_pkg::PENDING_STATUS_OFFSET, 32'h000F0002,
			timer_mask_stop_pkg::RESP_OKAY);
		wr(timer_mask_stop_pkg::MASK_SET_OFFSET, 32'h00010000, timer_mask_stop_pkg::RESP_OKAY);
		repeat (2) @(negedge clk);
		chk("half request", 32'h0000000E, {24'h0, half_match_irq});
		$display("masking done");
		// Only byte lane 2 is strobed, so the full-match mask in lane 0 must survive.
		@(posedge clk);
		wstrb <= 4'h4;
		wr(timer_mask_stop_pkg::MASK_CLEAR_OFFSET, 32'h00010001,
			timer_mask_stop_pkg::RESP_OKAY);
		wstrb <= 4'hF;
		rd(timer_mask_stop_pkg::MASK_STATUS_OFFSET, 32'h00000001,
			timer_mask_stop_pkg::RESP_OKAY);
		$display("strobe done");
		@(posedge clk);
		clock_enable <= 1'b0;
		@(negedge clk);
		chk("readies while frozen", 32'h0, {29'h0, awready, wready, arready});
		$display("frozen done");
		@(posedge clk);
		clock_enable <= 1'b1;
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		chk("enables after reset", 32'h000001FF,
			{23'h0, watchdog_clock_enable, channel_clock_enable});
		rd(timer_mask_stop_pkg::MASK_STATUS_OFFSET, 32'h00000000,
			timer_mask_stop_pkg::RESP_OKAY);
		rd(timer_mask_stop_pkg::STOP_STATUS_OFFSET, 32'h00000000,
			timer_mask_stop_pkg::RESP_OKAY);
		$display("reset done");
		stop_test();
	end
endmodule // tb
